// >>> logic/flash_status_host.sv
// Host controller that polls and manages flash status registers
//
// Contract
// - Host masks reserved compatible bits 2 to 0 when polling.
// - Host checks ready before trusting suspend and result bits.
// - Both error bits set means bad sequence; host flags seq_error until an OP_CLEAR request or a ready read without both bits.
// - Config bits 2 to 0 pick ready pin mode; upper bits zero.
// - Lock bits read locked until upload-status-bits is issued.
// - Extended status read address picks global or block register.
`timescale 1ns/100ps
module flash_status_host #(
  parameter int ADDR_W = 21
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // User side
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire flash_host_pkg::host_op_t      req_op,
  input  wire logic [ADDR_W-1:0]             req_addr,
  input  wire logic [2:0]                    req_cfg,
  output logic                               rsp_valid,
  output logic [flash_host_pkg::DATA_W-1:0]  rsp_data,
  output logic                               rsp_done,
  output logic                               op_fail,
  output logic                               seq_error,
  output logic                               volt_error,
  output logic                               suspended,
  output logic                               locked,
  // Flash pins
  output logic [ADDR_W-1:0]                  flash_addr,
  output logic                               flash_ce_n,
  output logic                               flash_we_n,
  output logic                               flash_oe_n,
  input  wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
  output logic [flash_host_pkg::DATA_W-1:0]  flash_dq_out,
  output logic                               flash_dq_oe,
  input  wire logic                          ready_busy_pin
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    IDLE, CMD1, CMD2, RD, DONE
  } st_t;

  st_t              st_r;
  host_op_t         op_r;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic             rb_s1_r, rb_s2_r;
  logic             cyc_start, cyc_wr, cyc_done;
  logic [DATA_W-1:0] cyc_wdata, cyc_rdata;

  // Synchronise the asynchronous flash pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= ready_busy_pin;
      rb_s2_r <= rb_s1_r;
    end
  end

  function automatic logic two_cmds(input host_op_t op);
    two_cmds = (op == OP_UPLOAD) || (op == OP_SET_CFG);
  endfunction

  function automatic logic [7:0] first_cmd(input host_op_t op);
    case (op)
      OP_READ_COMPAT: first_cmd = CMD_READ_COMPAT;
      OP_READ_EXT:    first_cmd = CMD_READ_EXT;
      OP_CLEAR:       first_cmd = CMD_CLEAR_STATUS;
      OP_UPLOAD:      first_cmd = CMD_UPLOAD_BITS;
      OP_SET_CFG:     first_cmd = CMD_READY_CFG;
      default:        first_cmd = CMD_READ_ARRAY;
    endcase
  endfunction

  assign req_ready = (st_r == IDLE);
  assign cyc_start = (st_r == CMD1) || (st_r == CMD2) || (st_r == RD);
  assign cyc_wr    = (st_r != RD);

  always_comb begin
    case (st_r)
      CMD1:    cyc_wdata = first_cmd(op_r);
      CMD2:    cyc_wdata = (op_r == OP_SET_CFG) ?
                 {5'h00, req_cfg} & CFG_MASK : CMD_CONFIRM;
      default: cyc_wdata = '0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= IDLE;
      op_r <= OP_READ_COMPAT;
    end else begin
      case (st_r)
        IDLE: begin
          if (req_valid) begin
            op_r <= req_op;
            st_r <= CMD1;
          end
        end
        CMD1: begin
          if (cyc_done) begin
            if (two_cmds(op_r)) begin
              st_r <= CMD2;
            end else if (op_r == OP_CLEAR) begin
              st_r <= DONE;
            end else begin
              st_r <= RD;
            end
          end
        end
        CMD2: begin
          if (cyc_done) begin
            st_r <= DONE;
          end
        end
        RD: begin
          if (cyc_done) begin
            st_r <= DONE;
          end
        end
        default: st_r <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_addr <= '0;
      flash_ce_n <= 1'b1;
    end else if (st_r == IDLE && req_valid) begin
      flash_addr <= req_addr;
      flash_ce_n <= 1'b0;
    end else if (st_r == DONE) begin
      flash_ce_n <= 1'b1;
    end
  end

  // Status decode; masking makes reserved bits harmless
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_data   <= '0;
      op_fail    <= 1'b0;
      seq_error  <= 1'b0;
      volt_error <= 1'b0;
      suspended  <= 1'b0;
      locked     <= 1'b1;
    end else if (st_r == DONE &&
                 (op_r == OP_READ_COMPAT || op_r == OP_READ_EXT)) begin
      // Read byte is registered at the end of the cycle, so decode a clock later
      if (op_r == OP_READ_COMPAT) begin
        rsp_data <= cyc_rdata & CS_MASK;
        // Results are only trusted once the machine is ready
        if (cyc_rdata[CS_READY] && rb_s2_r) begin
          suspended  <= cyc_rdata[CS_SUSPEND];
          op_fail    <= cyc_rdata[CS_ERASE_ER] | cyc_rdata[CS_PROG_ER];
          seq_error  <= cyc_rdata[CS_ERASE_ER] & cyc_rdata[CS_PROG_ER];
          volt_error <= cyc_rdata[CS_VOLT_ER];
        end
      end else if (flash_addr == ADDR_W'(EXT_GLOBAL_ADDR)) begin
        // Global bit 0 is the buffer select, so nothing is masked
        rsp_data <= cyc_rdata;
      end else begin
        rsp_data <= cyc_rdata & BS_MASK;
        if (cyc_rdata[BS_READY]) begin
          locked <= !cyc_rdata[BS_UNLOCK];
        end
      end
    end else if (st_r == CMD1 && cyc_done && op_r == OP_CLEAR) begin
      op_fail    <= 1'b0;
      seq_error  <= 1'b0;
      volt_error <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_done  <= 1'b0;
    end else begin
      rsp_valid <= (st_r == DONE) &&
                   (op_r == OP_READ_COMPAT || op_r == OP_READ_EXT);
      rsp_done  <= (st_r == DONE);
    end
  end

  bus_cycle #(.W(DATA_W)) u_cycle (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (cyc_start),
    .is_write (cyc_wr),
    .wdata    (cyc_wdata),
    .dq_sync  (dq_s2_r),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .we_n     (flash_we_n),
    .oe_n     (flash_oe_n),
    .dq_out   (flash_dq_out),
    .dq_oe    (flash_dq_oe)
  );
endmodule

// >>> logic/flash_host_pkg.sv
// Command codes, status bit positions and timing for the flash status host
package flash_host_pkg;
  localparam int DATA_W = 8;
  // Command bytes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_COMPAT  = 8'h70;
  localparam logic [7:0] CMD_READ_EXT     = 8'h71;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_UPLOAD_BITS  = 8'h97;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_READY_CFG    = 8'h96;
  // Compatible status bits
  localparam int CS_READY    = 7;
  localparam int CS_SUSPEND  = 6;
  localparam int CS_ERASE_ER = 5;
  localparam int CS_PROG_ER  = 4;
  localparam int CS_VOLT_ER  = 3;
  localparam logic [7:0] CS_MASK = 8'hF8;
  // Global status bits
  localparam int GS_READY   = 7;
  localparam int GS_SUSPEND = 6;
  localparam int GS_FAIL    = 5;
  localparam int GS_SLEEP   = 4;
  localparam int GS_QFULL   = 3;
  localparam int GS_BUFFREE = 2;
  localparam int GS_SELRDY  = 1;
  localparam int GS_BUFSEL  = 0;
  // Block status bits
  localparam int BS_READY   = 7;
  localparam int BS_UNLOCK  = 6;
  localparam int BS_FAIL    = 5;
  localparam int BS_ABORT   = 4;
  localparam int BS_QFULL   = 3;
  localparam int BS_VOLT_ER = 2;
  localparam int BS_VOLT_LV = 1;
  localparam logic [7:0] BS_MASK = 8'hFE;
  // Extended status address that selects the global register
  localparam int EXT_GLOBAL_ADDR = 0;
  // Ready pin configuration codes
  localparam logic [2:0] RDY_LEVEL  = 3'h1;
  localparam logic [2:0] RDY_P_PROG = 3'h2;
  localparam logic [2:0] RDY_P_ERAS = 3'h3;
  localparam logic [2:0] RDY_OFF    = 3'h4;
  localparam logic [2:0] RDY_P_BOTH = 3'h5;
  localparam logic [7:0] CFG_MASK   = 8'h07;
  // Bus timing in ns, 10 MHz clock
  localparam int CLK_NS      = 100;
  localparam int STROBE_NS   = 100;
  localparam int STROBE_CYC  =
    (STROBE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
    (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  typedef enum logic [2:0] {
    OP_READ_COMPAT, OP_READ_EXT, OP_CLEAR, OP_UPLOAD, OP_SET_CFG
  } host_op_t;
endpackage

// >>> logic/bus_cycle.sv
// One write or read strobe cycle on the flash parallel data pins
`timescale 1ns/100ps
module bus_cycle #(
  parameter int W = 8
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                start,
  input  wire logic                is_write,
  input  wire logic [W-1:0]        wdata,
  input  wire logic [W-1:0]        dq_sync,
  output logic                     done,
  output logic [W-1:0]             rdata,
  output logic                     we_n,
  output logic                     oe_n,
  output logic [W-1:0]             dq_out,
  output logic                     dq_oe
);
  import flash_host_pkg::*;
  logic [3:0] cnt_r;
  logic       busy_r;
  logic       wr_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      cnt_r  <= 4'h0;
      wr_r   <= 1'b0;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1;
      wr_r   <= is_write;
      // Two extra cycles cover the pin synchroniser latency on reads
      cnt_r  <= STROBE_CNT + 4'h2;
    end else if (busy_r) begin
      cnt_r  <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_out <= '0;
    end else if (start && !busy_r) begin
      dq_out <= wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (busy_r && !wr_r && cnt_r == 4'h1) begin
      rdata <= dq_sync;
    end
  end

  assign done   = busy_r && cnt_r == 4'h1;
  assign we_n   = !(busy_r && wr_r);
  assign oe_n   = !(busy_r && !wr_r);
  assign dq_oe  = busy_r && wr_r;
endmodule

// >>> testbench/flash_status_host_monitor.sv
// Checker for the flash status host pin and response timing
`timescale 1ns/100ps
module flash_status_host_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       req_ready,
  input wire logic       rsp_valid,
  input wire logic       rsp_done,
  input wire logic [7:0] rsp_data,
  input wire logic [20:0] flash_addr,
  input wire logic       flash_ce_n,
  input wire logic       flash_we_n,
  input wire logic       flash_oe_n,
  input wire logic       flash_dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_READ_BUS: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("read strobe with host driving data");
  AST_WRITE_BUS: assert property (!flash_we_n |-> flash_dq_oe && flash_oe_n)
    else $error("write strobe without data driven");
  AST_WE_BOUND: assert property ($fell(flash_we_n) |-> ##[1:4] flash_we_n)
    else $error("write strobe too long");
  AST_OE_BOUND: assert property ($fell(flash_oe_n) |-> ##[1:4] flash_oe_n)
    else $error("read strobe too long");
  AST_RSP_PAIR: assert property (rsp_valid |-> rsp_done)
    else $error("read data without completion");
  AST_RSP_PULSE: assert property (rsp_done |=> !rsp_done)
    else $error("completion longer than one cycle");
  AST_RESERVED_MASK: assert property (rsp_valid && flash_addr != 21'h0_0000
    |-> !rsp_data[0])
    else $error("reserved status bit not masked");
  AST_READ_CAUSE: assert property (rsp_valid |->
    !$past(flash_oe_n) || !$past(flash_oe_n, 2) || !$past(flash_oe_n, 3))
    else $error("read data without a read strobe");
  AST_NO_ACCEPT_MID: assert property (!flash_we_n |-> !req_ready)
    else $error("request accepted during a bus cycle");
  cover property (rsp_valid);
  cover property ($fell(flash_we_n));
  cover property (rsp_done && !rsp_valid);
endmodule

bind flash_status_host flash_status_host_monitor u_flash_status_host_monitor (
  .clk, .sys_rst, .req_ready, .rsp_valid, .rsp_done, .rsp_data,
  .flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_oe);

// >>> testbench/flash_dev_model.sv
// Behavioural flash device answering status reads and config writes
`timescale 1ns/100ps
module flash_dev_model (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [20:0] addr,
  input  wire logic [7:0]  dq_host,
  output logic [7:0]       dq_dev,
  output logic             rdy_pin
);
  // Scenarios preload these to pose status patterns
  // Voltage bit moves only when a scenario preloads it or the 50h clear command resets it
  logic [7:0] compat_r = 8'h80;
  logic [7:0] glob_r   = 8'h86;
  logic [7:0] blk_r    = 8'h80;
  logic [7:0] cfg_r    = 8'h01;
  logic [7:0] cmd_r    = 8'hFF;
  logic [7:0] last_r   = 8'h00;
  logic [7:0] rd_nxt;
  always @(posedge we_n) begin
    if (!ce_n) begin
      if (cmd_r == 8'h96) begin
        cfg_r = {5'h0, dq_host[2:0]};
        cmd_r = 8'hFF;
      end else if (cmd_r == 8'h97) begin
        if (dq_host == 8'hD0) blk_r[6] = 1'b1;
        cmd_r = 8'hFF;
      end else begin
        cmd_r = dq_host;
        if (dq_host == 8'h50) begin
          compat_r[5:3] = 3'h0;
          glob_r[5] = 1'b0;
          blk_r = blk_r & 8'hCB;
        end
      end
    end
  end
  always_comb begin
    if (cmd_r == 8'h71) rd_nxt = (addr == '0) ? glob_r : blk_r;
    else rd_nxt = compat_r;
  end
  always @(negedge oe_n) last_r = rd_nxt;
  // Released bus shows the inverse so a late sample cannot pass
  assign dq_dev  = (!oe_n && !ce_n) ? rd_nxt : ~last_r;
  assign rdy_pin = compat_r[7] | (cfg_r[2:0] == 3'h4);
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the flash status host controller
`timescale 1ns/100ps
module testbench;
  import flash_host_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  host_op_t    req_op = OP_READ_COMPAT;
  logic [20:0] req_addr = 21'h0_0000;
  logic [2:0]  req_cfg = 3'h1;
  logic [7:0]  rsp_data, flash_dq_in, flash_dq_out, dev_dq, got;
  logic [20:0] flash_addr;
  logic        req_ready, rsp_valid, rsp_done, op_fail, seq_error;
  logic        volt_error, suspended, locked, ready_busy_pin;
  logic        flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #50 clk = ~clk;
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dev_dq;
  flash_status_host u_flash_status_host (
    .clk, .sys_rst, .req_valid, .req_ready, .req_op, .req_addr, .req_cfg,
    .rsp_valid, .rsp_data, .rsp_done, .op_fail, .seq_error, .volt_error,
    .suspended, .locked, .flash_addr, .flash_ce_n, .flash_we_n,
    .flash_oe_n, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
    .ready_busy_pin);
  flash_dev_model u_flash_dev_model (.ce_n(flash_ce_n), .we_n(flash_we_n),
    .oe_n(flash_oe_n), .addr(flash_addr), .dq_host(flash_dq_out),
    .dq_dev(dev_dq), .rdy_pin(ready_busy_pin));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic do_op(input host_op_t op, input logic [20:0] a,
                       input logic [2:0] c);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_cfg <= c;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      if (rsp_done === 1'b1) break;
    end
    got = rsp_data;
    chk({7'h0, rsp_done}, 8'h01);
    chk({7'h0, rsp_valid},
        {7'h0, op == OP_READ_COMPAT || op == OP_READ_EXT});
  endtask
  task automatic t_upload();
    do_op(OP_READ_EXT, 21'h0_0002, 3'h1);
    chk(got, 8'h80);
    chk({7'h0, locked}, 8'h01);
    do_op(OP_UPLOAD, 21'h0_0000, 3'h1);
    do_op(OP_READ_EXT, 21'h0_0002, 3'h1);
    chk(got, 8'hC0);
    chk({7'h0, locked}, 8'h00);
  endtask
  task automatic t_compat();
    // Reserved bits set on purpose so masking is seen
    u_flash_dev_model.compat_r = 8'hFF;
    do_op(OP_READ_COMPAT, 21'h0_0000, 3'h1);
    chk(got, 8'hF8);
    chk({4'h0, op_fail, seq_error, volt_error, suspended}, 8'h0F);
    chk({7'h0, suspended}, 8'h01);
    chk({7'h0, volt_error}, 8'h01);
    do_op(OP_CLEAR, 21'h0_0000, 3'h1);
    do_op(OP_READ_COMPAT, 21'h0_0000, 3'h1);
    chk(got, 8'hC0);
    chk({4'h0, op_fail, seq_error, volt_error, suspended}, 8'h01);
  endtask
  task automatic t_busy();
    // Busy with stale result bits: seq_error and volt_error must not pick them up
    u_flash_dev_model.compat_r = 8'h38;
    do_op(OP_READ_COMPAT, 21'h0_0000, 3'h1);
    chk(got, 8'h38);
    chk({7'h0, seq_error}, 8'h00);
    chk({7'h0, volt_error}, 8'h00);
    u_flash_dev_model.compat_r = 8'h80;
  endtask
  task automatic t_ext();
    u_flash_dev_model.blk_r = 8'hFF;
    // Global still busy while the addressed block already reports ready
    u_flash_dev_model.glob_r = 8'h5F;
    do_op(OP_READ_EXT, 21'h0_0002, 3'h1);
    chk(got, 8'hFE);
    chk({6'h0, got[5:4]}, 8'h03);
    chk({7'h0, got[7]}, 8'h01);
    do_op(OP_READ_EXT, 21'h0_0000, 3'h1);
    chk(got, 8'h5F);
    chk({7'h0, got[7]}, 8'h00);
    chk({7'h0, got[6]}, 8'h01);
    chk({6'h0, got[5:4]}, 8'h01);
    chk({7'h0, got[3]}, 8'h01);
    chk({7'h0, got[0]}, 8'h01);
  endtask
  task automatic t_cfg();
    logic [2:0] m;
    for (m = 3'h1; m <= 3'h5; m++) begin
      do_op(OP_SET_CFG, 21'h0_0000, m);
      chk(u_flash_dev_model.cfg_r, {5'h0, m});
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    @(negedge clk);
    chk({3'h0, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, locked},
        8'h1D);
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_upload();
    t_compat();
    t_busy();
    t_ext();
    t_cfg();
    print_verdict();
  end
endmodule
